// file: rtl/tid_pkg.sv
// Package for the timer interrupt and DMA control block
`default_nettype none
package tid_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_COUNTER_PTR = 8'hf0;
  localparam logic [7:0] IDX_ADDRESS_PTR = 8'hf1;
  localparam logic [7:0] IDX_VECTOR = 8'hf2;
  localparam logic [7:0] IDX_CONTROL = 8'hf3;
  localparam logic [7:0] IDX_MASK = 8'hf4;
  localparam logic [7:0] IDX_MODE = 8'hf5;
  localparam logic [7:0] IDX_COUNT = 8'hf6;
  localparam logic [7:0] IDX_LOOP = 8'hf8;
  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'hc7;
  localparam logic [7:0] RST_LOOP = 8'hfc;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Mask register fields
  localparam int MSK_GLOBAL = 7;
  localparam int MSK_CAP0_DMA = 6;
  localparam int MSK_CAP0_IRQ = 5;
  localparam int MSK_CAP1_IRQ = 4;
  localparam int MSK_CMP0_DMA = 3;
  localparam int MSK_CMP0_IRQ = 2;
  localparam int MSK_CMP1_IRQ = 1;
  localparam int MSK_WRAP_IRQ = 0;
  // Control register fields
  localparam int CTL_CAP_END = 7;
  localparam int CTL_CMP_END = 6;
  localparam int CTL_SRC_SEL = 5;
  localparam int CTL_DST_SEL = 4;
  localparam int CTL_SWAP = 3;
  localparam int CTL_LEVEL_LO = 0;
  // Pointer register fields, then the vector base low bit
  localparam int PTR_TOGGLE = 2;
  localparam int PTR_CHANNEL = 1;
  localparam int PTR_SELECT = 0;
  localparam int VEC_BASE_LO = 3;
  // Mode register field
  localparam int MODE_COMBINE = 0;
  // Vector group codes
  localparam logic [1:0] GRP_WRAP = 2'h0;
  localparam logic [1:0] GRP_CAPTURE = 2'h2;
  localparam logic [1:0] GRP_COMPARE = 2'h3;
  // Timer events, one-cycle pulses
  typedef struct packed {
    logic cap0;
    logic cap1;
    logic cmp0;
    logic cmp1;
    logic wrap;
  } tid_event_t;
  // DMA request to the chip controller
  typedef struct packed {
    logic req;
    logic channel;
    logic to_regfile;
    logic extender_select;
    logic capture_dma_source_sel;
    logic compare_dma_dest_sel;
    logic [7:0] counter_ptr;
    logic [7:0] address_ptr;
  } tid_dma_req_t;
  // Interrupt request to the chip controller
  typedef struct packed {
    logic req;
    logic [7:0] vector;
    logic [2:0] priority_level;
  } tid_irq_t;
endpackage
`default_nettype wire

// file: rtl/tid_ctrl.sv
// Timer interrupt and DMA control section with APB register access
// Operation
// - Capture-0 DMA enable is set by software, cleared at its block end
// - Compare-0 DMA enable is set by software, cleared at its block end
// - Capture-0 mask raises interrupt per event, or at block end with DMA
// - Compare-0 mask raises interrupt per match, or at block end with DMA
// - Separate masks for capture-1, compare-1 and counter wrap interrupts
// - Counter pointer high bits by software; lowest toggles in swap mode
// - Hardware channel bit: 0 capture-0 channel, 1 compare-0 channel
// - Area select bit: 0 memory, 1 register file
// - Address pointer high bits by software; lowest toggles in swap mode
// - Register-file DMA ignores address pointer except swap table bit
// - Extender select applies to memory DMA only: 0 first, 1 DMA segment
// - Vector bits 7:3 by software, form an 8-bit vector address
// - Vector bits 2:1 give group: 00 wrap, 10 capture, 11 compare
// - One vector per group; software reads event flags for source
// - Capture block-end flag set at block end in swap, else held at 1
// - Compare block-end flag set at block end in swap, else held at 1
// - Capture DMA source: 0 capture-0 register, 1 I/O port
// - Compare DMA destination: 0 compare-0 register, 1 I/O port
// - Swap enable acts on both DMA channels together
// - Three-bit priority level presented to the chip controller
// - Loop bits link output A to input A: odd bit 1/3, even bit 0/2
// - Global enable gates every timer interrupt
// - Capture combine: 0 OR of both captures, 1 AND of both
`default_nettype none
module tid_ctrl
  import tid_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire tid_event_t EVENTS,
  input wire logic DMA_DONE,
  input wire logic IRQ_ACK,
  output tid_dma_req_t DMA_REQ,
  output tid_irq_t IRQ,
  input wire logic [3:0] TIMER_OUT_A,
  input wire logic [3:0] PIN_IN_A,
  output logic [3:0] TIMER_IN_A
);
  logic [7:0] counter_ptr;
  logic [7:0] address_ptr;
  logic [7:0] vector_base;
  logic [7:0] control;
  logic [7:0] mask;
  logic [7:0] mode;
  logic [7:0] loop_ctl;
  logic [7:0] cap_count;
  logic [7:0] cmp_count;
  logic channel;
  logic dma_cap_pend;
  logic dma_cmp_pend;
  logic p_cap0, p_cap1, p_cmp0, p_cmp1, p_wrap;
  logic [1:0] vec_group;
  logic irq_req;
  logic [3:0] pin_meta, pin_sync;
  logic [31:0] next_rdata;

  // APB decode; the slave always answers in the first access cycle
  wire [7:0] idx = PADDR[9:2];
  wire setup = PSEL && !PENABLE;
  wire wr = PSEL && PENABLE && PWRITE;
  wire hit_cptr = idx == IDX_COUNTER_PTR;
  wire hit_aptr = idx == IDX_ADDRESS_PTR;
  wire hit_vec = idx == IDX_VECTOR;
  wire hit_ctl = idx == IDX_CONTROL;
  wire hit_msk = idx == IDX_MASK;
  wire hit_mode = idx == IDX_MODE;
  wire hit_cnt = idx == IDX_COUNT;
  wire hit_loop = idx == IDX_LOOP;
  wire mapped = (PADDR[11:10] == 2'h0) && (hit_cptr || hit_aptr || hit_vec ||
    hit_ctl || hit_msk || hit_mode || hit_cnt || hit_loop);
  wire wr_ok = wr && mapped;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // Control views
  wire swap = control[CTL_SWAP];
  wire combine = mode[MODE_COMBINE];
  wire cap_dma_en = mask[MSK_CAP0_DMA];
  wire cmp_dma_en = mask[MSK_CMP0_DMA];

  // A transfer on the served channel ends the block when its count hits zero
  wire done_cap = DMA_DONE && !channel;
  wire done_cmp = DMA_DONE && channel;
  wire cap_eob = done_cap && cap_count == 8'h01;
  wire cmp_eob = done_cmp && cmp_count == 8'h01;
  wire any_eob = cap_eob || cmp_eob;

  // Interrupt source events: with DMA on, block end replaces the raw event
  wire src_cap0 = cap_dma_en ? cap_eob : EVENTS.cap0;
  wire src_cmp0 = cmp_dma_en ? cmp_eob : EVENTS.cmp0;
  wire m_cap0 = p_cap0 && mask[MSK_CAP0_IRQ];
  wire m_cap1 = p_cap1 && mask[MSK_CAP1_IRQ];
  wire m_cmp = (p_cmp0 && mask[MSK_CMP0_IRQ]) ||
    (p_cmp1 && mask[MSK_CMP1_IRQ]);
  wire m_wrap = p_wrap && mask[MSK_WRAP_IRQ];
  wire grp_cap = combine ? (m_cap0 && m_cap1) : (m_cap0 || m_cap1);
  // Fixed group order: wrap, then capture, then compare
  wire [1:0] next_group = m_wrap ? GRP_WRAP :
    grp_cap ? GRP_CAPTURE : GRP_COMPARE;
  wire any_grp = m_wrap || grp_cap || m_cmp;
  wire next_irq = mask[MSK_GLOBAL] && any_grp;
  wire ack_wrap = IRQ_ACK && vec_group == GRP_WRAP;
  wire ack_cap = IRQ_ACK && vec_group == GRP_CAPTURE;
  wire ack_cmp = IRQ_ACK && vec_group == GRP_COMPARE;

  // Read mux; hardware-owned bits show live state
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_cptr) begin
      next_rdata[7:0] = counter_ptr;
    end else if (hit_aptr) begin
      next_rdata[7:0] = address_ptr;
    end else if (hit_vec) begin
      next_rdata[7:0] = {vector_base[7:VEC_BASE_LO], vec_group, 1'b0};
    end else if (hit_ctl) begin
      next_rdata[7:0] = control;
    end else if (hit_msk) begin
      next_rdata[7:0] = mask;
    end else if (hit_mode) begin
      next_rdata[7:0] = mode;
    end else if (hit_cnt) begin
      next_rdata[15:0] = {cmp_count, cap_count};
    end else if (hit_loop) begin
      next_rdata[7:0] = loop_ctl;
    end
  end

  // Read data is captured in the setup cycle
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup) begin
      PRDATA <= next_rdata;
    end
  end

  // Pointers: swap toggles the table bit of both pointers at block end
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      counter_ptr <= RST_BYTE;
      address_ptr <= RST_BYTE;
    end else begin
      if (wr_ok && hit_cptr) begin
        counter_ptr[7:2] <= PWDATA[7:2];
        counter_ptr[PTR_SELECT] <= PWDATA[PTR_SELECT];
      end else if (swap && any_eob) begin
        counter_ptr[PTR_TOGGLE] <= !counter_ptr[PTR_TOGGLE];
      end
      if (wr_ok && hit_aptr) begin
        address_ptr[7:2] <= PWDATA[7:2];
        address_ptr[PTR_SELECT] <= PWDATA[PTR_SELECT];
      end else if (swap && any_eob) begin
        address_ptr[PTR_TOGGLE] <= !address_ptr[PTR_TOGGLE];
      end
      counter_ptr[PTR_CHANNEL] <= channel;
      address_ptr[PTR_CHANNEL] <= channel;
    end
  end

  // Vector base, mode and loop settings are software-owned
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      vector_base <= RST_BYTE;
      mode <= RST_BYTE;
      loop_ctl <= RST_LOOP;
    end else if (wr_ok) begin
      if (hit_vec) vector_base <= {PWDATA[7:3], 3'h0};
      if (hit_mode) mode <= PWDATA[7:0];
      if (hit_loop) loop_ctl <= PWDATA[7:0];
    end
  end

  // Control: block-end flags are set-wins, and held at 1 while swap is off
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      control <= RST_CONTROL;
    end else begin
      if (wr_ok && hit_ctl) begin
        control[5:0] <= PWDATA[5:0];
      end
      if (!swap || cap_eob) begin
        control[CTL_CAP_END] <= 1'b1;
      end else if (wr_ok && hit_ctl) begin
        control[CTL_CAP_END] <= PWDATA[CTL_CAP_END];
      end
      if (!swap || cmp_eob) begin
        control[CTL_CMP_END] <= 1'b1;
      end else if (wr_ok && hit_ctl) begin
        control[CTL_CMP_END] <= PWDATA[CTL_CMP_END];
      end
    end
  end

  // Mask: block end clears the DMA enables even against a same-cycle write
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      mask <= RST_BYTE;
    end else begin
      if (wr_ok && hit_msk) mask <= PWDATA[7:0];
      if (cap_eob) mask[MSK_CAP0_DMA] <= 1'b0;
      if (cmp_eob) mask[MSK_CMP0_DMA] <= 1'b0;
    end
  end

  // Transaction counts; a transfer decrement wins over a software load
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      cap_count <= RST_BYTE;
      cmp_count <= RST_BYTE;
    end else begin
      if (done_cap && cap_count != 8'h00) begin
        cap_count <= cap_count - 8'h01;
      end else if (wr_ok && hit_cnt) begin
        cap_count <= PWDATA[7:0];
      end
      if (done_cmp && cmp_count != 8'h00) begin
        cmp_count <= cmp_count - 8'h01;
      end else if (wr_ok && hit_cnt) begin
        cmp_count <= PWDATA[15:8];
      end
    end
  end

  // Channel is picked from the next pending state, so a fresh request and
  // the one left after a transfer never start on a stale channel
  wire next_cap_pend = (cap_dma_en && EVENTS.cap0) ||
    (dma_cap_pend && !done_cap);
  wire next_cmp_pend = (cmp_dma_en && EVENTS.cmp0) ||
    (dma_cmp_pend && !done_cmp);

  // DMA requests wait for a transfer; capture channel is served first
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      dma_cap_pend <= 1'b0;
      dma_cmp_pend <= 1'b0;
      channel <= 1'b0;
    end else begin
      dma_cap_pend <= next_cap_pend;
      dma_cmp_pend <= next_cmp_pend;
      if (!DMA_REQ.req || DMA_DONE) begin
        channel <= !next_cap_pend && next_cmp_pend;
      end
    end
  end

  // Request outputs; the pointer select bits steer area and extender
  assign DMA_REQ.req = dma_cap_pend || dma_cmp_pend;
  assign DMA_REQ.channel = channel;
  assign DMA_REQ.to_regfile = counter_ptr[PTR_SELECT];
  assign DMA_REQ.extender_select = !counter_ptr[PTR_SELECT] &&
    address_ptr[PTR_SELECT];
  assign DMA_REQ.capture_dma_source_sel = control[CTL_SRC_SEL];
  assign DMA_REQ.compare_dma_dest_sel = control[CTL_DST_SEL];
  assign DMA_REQ.counter_ptr = counter_ptr;
  // Register-file transfers only keep the swap table bit of the pointer
  assign DMA_REQ.address_ptr = counter_ptr[PTR_SELECT] ?
    {5'h00, address_ptr[PTR_TOGGLE], 2'h0} : address_ptr;

  // Pending interrupt sources; a new event wins over an acknowledge
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      p_cap0 <= 1'b0;
      p_cap1 <= 1'b0;
      p_cmp0 <= 1'b0;
      p_cmp1 <= 1'b0;
      p_wrap <= 1'b0;
    end else begin
      p_cap0 <= src_cap0 || (p_cap0 && !ack_cap);
      p_cap1 <= EVENTS.cap1 || (p_cap1 && !ack_cap);
      p_cmp0 <= src_cmp0 || (p_cmp0 && !ack_cmp);
      p_cmp1 <= EVENTS.cmp1 || (p_cmp1 && !ack_cmp);
      p_wrap <= EVENTS.wrap || (p_wrap && !ack_wrap);
    end
  end

  // Request and vector come from flops so they always agree
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      irq_req <= 1'b0;
      vec_group <= GRP_WRAP;
    end else begin
      irq_req <= next_irq;
      // Group holds when idle, so a read shows the latest vector
      if (any_grp) begin
        vec_group <= next_group;
      end
    end
  end
  assign IRQ.req = irq_req;
  assign IRQ.vector = {vector_base[7:VEC_BASE_LO], vec_group, 1'b0};
  assign IRQ.priority_level = control[CTL_LEVEL_LO +: 3];

  // Pin inputs pass three flops; loopback bypasses the pad entirely
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      TIMER_IN_A <= 4'h0;
    end else begin
      pin_meta <= PIN_IN_A;
      pin_sync <= pin_meta;
      for (int t = 0; t < 4; t++) begin
        TIMER_IN_A[t] <= loop_ctl[t % 2] ? TIMER_OUT_A[t] : pin_sync[t];
      end
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  chk_cap_dma_clear: assert property (cap_eob |=> !mask[MSK_CAP0_DMA])
    else $error("capture DMA enable not cleared at block end");
  chk_cmp_dma_clear: assert property (cmp_eob |=> !mask[MSK_CMP0_DMA])
    else $error("compare DMA enable not cleared at block end");
  chk_cap_end_held: assert property (!swap |=> control[CTL_CAP_END])
    else $error("capture block-end flag not held with swap off");
  chk_swap_toggle_ptr: assert property (swap && cmp_eob && !(wr_ok && hit_cptr)
    |=> counter_ptr[PTR_TOGGLE] != $past(counter_ptr[PTR_TOGGLE]))
    else $error("counter pointer table bit did not toggle");
  chk_vector_code: assert property (IRQ.vector[0] == 1'b0 &&
    IRQ.vector[2:1] != 2'h1)
    else $error("illegal vector low bits");
  chk_global_gate: assert property (!mask[MSK_GLOBAL] |=> !IRQ.req)
    else $error("interrupt raised with global enable off");
  chk_and_combine: assert property (combine && p_cap0 && !p_cap1 &&
    !m_wrap && !m_cmp |=> !irq_req)
    else $error("capture group raised with one capture under AND");
  chk_count_step: assert property (done_cap && cap_count != 8'h00
    |=> cap_count == $past(cap_count) - 8'h01)
    else $error("capture count did not decrement");
  chk_loop_link: assert property (loop_ctl[0] ##1 loop_ctl[0]
    |-> TIMER_IN_A[0] == $past(TIMER_OUT_A[0]))
    else $error("loop link did not pass output A");
  chk_channel_cmp: assert property (
    DMA_REQ.req && !dma_cap_pend |-> channel)
    else $error("compare request not on the compare channel");

  cov_cap_block_end: cover property (cap_dma_en ##[1:20] cap_eob);
  cov_swap_end: cover property (swap && cmp_eob);
  cov_irq_ack: cover property (IRQ.req && IRQ_ACK ##2 !IRQ.req);
endmodule
`default_nettype wire

// file: sim/tid_chip_model.sv
// Behavioural model of the chip interrupt and DMA controller
`default_nettype none
module tid_chip_model
  import tid_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire tid_dma_req_t DMA_REQ,
  input wire tid_irq_t IRQ,
  input wire logic SLOW,
  output logic DMA_DONE,
  output logic IRQ_ACK
);
  logic [3:0] stall;
  logic acked;
  logic [7:0] acked_vec;
  wire logic [3:0] stall_end = SLOW ? 4'h6 : 4'h0;
  wire logic new_irq = IRQ.req && (!acked || IRQ.vector != acked_vec);

  // One transfer per request; no done in the cycle after a done, while req still lingers
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      DMA_DONE <= 1'b0;
      stall <= 4'h0;
    end else begin
      DMA_DONE <= 1'b0;
      if (DMA_REQ.req && !DMA_DONE) begin
        stall <= stall + 4'h1;
        if (stall >= stall_end) begin
          DMA_DONE <= 1'b1;
          stall <= 4'h0;
        end
      end
    end
  end

  // Ack once; the request lingers a cycle after an ack, so wait for a change
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      IRQ_ACK <= 1'b0;
      acked <= 1'b0;
      acked_vec <= 8'h00;
    end else begin
      IRQ_ACK <= 1'b0;
      if (new_irq && !IRQ_ACK) begin
        IRQ_ACK <= 1'b1;
        acked <= 1'b1;
        acked_vec <= IRQ.vector;
      end else if (!IRQ.req) begin
        acked <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/timer_interrupt_dma_control_bench.sv
// Self-checking bench for the timer interrupt and DMA control block
`default_nettype none
module timer_interrupt_dma_control_bench
  import tid_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] VEC_BASE = 5'h15;
  logic CLK_SYS = 1'b0;
  logic RSTN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  tid_event_t EVENTS = '0;
  logic DMA_DONE;
  logic IRQ_ACK;
  tid_dma_req_t DMA_REQ;
  tid_irq_t IRQ;
  logic [3:0] TIMER_OUT_A = 4'h0;
  logic [3:0] PIN_IN_A = 4'h0;
  logic [3:0] TIMER_IN_A;
  logic SLOW = 1'b0;
  int err_total = 0;
  int num_checks = 0;

  tid_ctrl i_dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EVENTS(EVENTS),
    .DMA_DONE(DMA_DONE), .IRQ_ACK(IRQ_ACK), .DMA_REQ(DMA_REQ), .IRQ(IRQ),
    .TIMER_OUT_A(TIMER_OUT_A), .PIN_IN_A(PIN_IN_A), .TIMER_IN_A(TIMER_IN_A));
  tid_chip_model i_chip (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .DMA_REQ(DMA_REQ),
    .IRQ(IRQ), .SLOW(SLOW), .DMA_DONE(DMA_DONE), .IRQ_ACK(IRQ_ACK));

  // Free-running system clock
  always #5 CLK_SYS = ~CLK_SYS;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds everything until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= {2'b00, idx, 2'b00};
    PWDATA <= wd;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (PREADY !== 1'b1) begin
      err_total++;
      $display("FAIL %0t no pready", $time);
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, d, rd, err);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 32'h0000_0000, rd, err);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0000_0000);
  endtask

  task automatic fire(input tid_event_t e);
    @(posedge CLK_SYS);
    EVENTS <= e;
    @(posedge CLK_SYS);
    EVENTS <= '0;
  endtask

  // Bounded wait for a level, then judge it
  task automatic wait_lvl(input bit dma, input logic lvl);
    int n;
    n = 0;
    while ((dma ? DMA_REQ.req : IRQ.req) !== lvl && n < 30) begin
      @(posedge CLK_SYS);
      n++;
    end
    chk({31'h0, dma ? DMA_REQ.req : IRQ.req}, {31'h0, lvl});
  endtask

  task automatic wait_irq(input logic [1:0] grp);
    wait_lvl(1'b0, 1'b1);
    chk({24'h0, IRQ.vector}, {24'h0, VEC_BASE, grp, 1'b0});
  endtask

  task automatic no_irq();
    logic seen;
    seen = 1'b0;
    repeat (6) begin
      @(posedge CLK_SYS);
      if (IRQ.req !== 1'b0) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h0000_0000);
  endtask

  task automatic settle();
    wait_lvl(1'b0, 1'b0);
    wait_lvl(1'b1, 1'b0);
    repeat (3) @(posedge CLK_SYS);
  endtask

  // Reset values, then an unmapped index
  task automatic t_reset();
    logic [31:0] rd;
    logic err;
    chk({29'h0, IRQ.priority_level}, 32'h0000_0007);
    rdc(IDX_COUNTER_PTR, 32'h0000_0000);
    rdc(IDX_ADDRESS_PTR, 32'h0000_0000);
    rdc(IDX_VECTOR, 32'h0000_0000);
    rdc(IDX_CONTROL, {24'h0, RST_CONTROL});
    rdc(IDX_MASK, 32'h0000_0000);
    rdc(IDX_COUNT, 32'h0000_0000);
    rdc(IDX_LOOP, {24'h0, RST_LOOP});
    apb(1'b0, 8'hf7, 32'h0000_0000, rd, err);
    chk({rd[31:1], err}, 32'h0000_0001);
  endtask

  // Each source alone, its group code, and the gating masks
  task automatic t_groups();
    tid_event_t ev [5] = '{5'h01, 5'h08, 5'h02, 5'h10, 5'h04};
    logic [7:0] msk [5] = '{8'h81, 8'h90, 8'h82, 8'ha0, 8'h84};
    logic [1:0] grp [5] = '{GRP_WRAP, GRP_CAPTURE, GRP_COMPARE,
      GRP_CAPTURE, GRP_COMPARE};
    wr(IDX_VECTOR, {24'h0, VEC_BASE, 3'h7});
    rdc(IDX_VECTOR, {24'h0, VEC_BASE, 3'h0});
    for (int i = 0; i < 5; i++) begin
      wr(IDX_MASK, {24'h0, msk[i]});
      fire(ev[i]);
      wait_irq(grp[i]);
      settle();
    end
    wr(IDX_MASK, 32'h0000_0001);
    fire(5'h01);
    no_irq();
    wr(IDX_MASK, 32'h0000_0080);
    fire(5'h01);
    no_irq();
  endtask

  // Captures combined by AND: one alone must stay quiet
  task automatic t_combine();
    wr(IDX_MODE, 32'h0000_0001);
    rdc(IDX_MODE, 32'h0000_0001);
    wr(IDX_MASK, 32'h0000_00b0);
    fire(5'h10);
    no_irq();
    fire(5'h18);
    wait_irq(GRP_CAPTURE);
    settle();
    wr(IDX_MODE, 32'h0000_0000);
  endtask

  // Capture DMA in swap mode to the register file, slow partner
  task automatic t_cap_dma();
    SLOW <= 1'b1;
    wr(IDX_CONTROL, 32'h0000_000d);
    wr(IDX_CONTROL, 32'h0000_000d);
    chk({29'h0, IRQ.priority_level}, 32'h0000_0005);
    rdc(IDX_CONTROL, 32'h0000_000d);
    wr(IDX_COUNTER_PTR, 32'h0000_0041);
    wr(IDX_ADDRESS_PTR, 32'h0000_0088);
    wr(IDX_COUNT, 32'h0000_0002);
    wr(IDX_MASK, 32'h0000_00e0);
    fire(5'h10);
    wait_lvl(1'b1, 1'b1);
    chk({30'h0, DMA_REQ.channel, DMA_REQ.to_regfile}, 32'h0000_0001);
    chk({24'h0, DMA_REQ.address_ptr}, 32'h0000_0000);
    chk({26'h0, DMA_REQ.counter_ptr[7:2]}, 32'h0000_0010);
    wait_lvl(1'b1, 1'b0);
    no_irq();
    rdc(IDX_COUNT, 32'h0000_0001);
    fire(5'h10);
    wait_lvl(1'b1, 1'b1);
    wait_irq(GRP_CAPTURE);
    settle();
    rdc(IDX_MASK, 32'h0000_00a0);
    rdc(IDX_COUNT, 32'h0000_0000);
    rdc(IDX_CONTROL, 32'h0000_008d);
    rdc(IDX_COUNTER_PTR, 32'h0000_0045);
    rdc(IDX_ADDRESS_PTR, 32'h0000_008c);
  endtask

  // Compare DMA to memory without swap, prompt partner
  task automatic t_cmp_dma();
    SLOW <= 1'b0;
    wr(IDX_CONTROL, 32'h0000_0037);
    rdc(IDX_CONTROL, 32'h0000_00f7);
    wr(IDX_COUNTER_PTR, 32'h0000_0080);
    wr(IDX_ADDRESS_PTR, 32'h0000_0061);
    wr(IDX_COUNT, 32'h0000_0100);
    wr(IDX_MASK, 32'h0000_008c);
    fire(5'h04);
    wait_lvl(1'b1, 1'b1);
    chk({30'h0, DMA_REQ.channel, DMA_REQ.to_regfile}, 32'h0000_0002);
    chk({29'h0, DMA_REQ.capture_dma_source_sel,
      DMA_REQ.compare_dma_dest_sel, DMA_REQ.extender_select},
      32'h0000_0007);
    chk({20'h0, DMA_REQ.address_ptr[7:2], DMA_REQ.counter_ptr[7:2]},
      32'h0000_0620);
    wait_irq(GRP_COMPARE);
    settle();
    rdc(IDX_MASK, 32'h0000_0084);
    rdc(IDX_CONTROL, 32'h0000_00f7);
  endtask

  // Loop links: bit 0 and bit 1 each select the output for their pair of timers
  task automatic t_loop();
    TIMER_OUT_A <= 4'b0011;
    PIN_IN_A <= 4'b1100;
    wr(IDX_LOOP, 32'h0000_00fd);
    rdc(IDX_LOOP, 32'h0000_00fd);
    repeat (5) @(posedge CLK_SYS);
    chk({28'h0, TIMER_IN_A}, 32'h0000_0009);
    wr(IDX_LOOP, 32'h0000_00fe);
    repeat (5) @(posedge CLK_SYS);
    chk({28'h0, TIMER_IN_A}, 32'h0000_0006);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence after ten cycles of reset
  initial begin
    repeat (10) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    t_reset();
    t_groups();
    t_combine();
    t_cap_dma();
    t_cmp_dma();
    t_loop();
    end_sim();
  end

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    err_total++;
    $display("FAIL %0t watchdog timeout", $time);
    end_sim();
  end
endmodule
`default_nettype wire
